// ### inc/gpio_dir_input_latch_regs.svh
`ifndef GPIO_DIR_INPUT_LATCH_REGS_SVH
`define GPIO_DIR_INPUT_LATCH_REGS_SVH

// ****************************************
// register offsets
// ****************************************
`define OFS_PORT_INPUT_LEVEL      12'h510
`define OFS_PIN_DIRECTION         12'h514
`define OFS_DIRECTION_SET_ALIAS   12'h518
`define OFS_DIRECTION_CLEAR_ALIAS 12'h51C
`define OFS_SENSE_HIT_LATCH       12'h520
`define OFS_WAKE_SIGNAL_SOURCE    12'h524
`define OFS_PIN_CONFIG_SENSE_LO   12'h600
`define OFS_PIN_CONFIG_SENSE_HI   12'h604
`define OFS_IRQ_STATUS            12'h608
`define OFS_IRQ_MASK              12'h60C

// ****************************************
// fields and reset values
// ****************************************
`define WAKE_SRC_BIT              0
`define IRQ_LATCH_BIT             0
`define IRQ_WAKE_BIT              1
`define RST_WORD                  32'h0000_0000

`endif

// ### inc/gpio_dir_input_latch_pkg.sv
package gpio_dir_input_latch_pkg;
   typedef logic [31:0] word_t;
   typedef logic [1:0]  sense_t;
   typedef enum logic [1:0] {
      SENSE_OFF  = 2'b00,
      SENSE_RSVD = 2'b01,
      SENSE_HIGH = 2'b10,
      SENSE_LOW  = 2'b11
   } sense_mode_e;
endpackage

// ### src/gpio_dir_input_latch.sv
`timescale 1ns/10ps
`include "gpio_dir_input_latch_regs.svh"

// Functional notes
// - input level register shows each pin's current level, zero is low
// - direction register, one is output, zero input, resets to all inputs
// - writing ones to set alias makes those pins outputs, zeros ignored
// - writing ones to clear alias makes those pins inputs, zeros ignored
// - reading either alias returns the direction register
// - latch bit becomes one once its pin meets its sense criterion
// - wake source bit picks raw detect signals or latched form
// - sense field: 0 off, 2 high level, 3 low level
module gpio_dir_input_latch
   import gpio_dir_input_latch_pkg::*;
#(
   // pins served by the port
   parameter int PIN_COUNT = 32
)
(
   // clock and reset
   input  wire  logic                              sys_clk,
   input  wire  logic                              rst_n,
   // apb slave
   input  wire  logic                              psel,
   input  wire  logic                              penable,
   input  wire  logic                              pwrite,
   input  wire  logic [11:0]                       paddr,
   input  wire  logic [31:0]                       pwdata,
   input  wire  logic [3:0]                        pstrb,
   output logic       [31:0]                       prdata,
   output logic                                    pready,
   output logic                                    pslverr,
   // pins
   input  wire  gpio_dir_input_latch_pkg::word_t   pin_in,
   output gpio_dir_input_latch_pkg::word_t         pin_dir,
   // wake and interrupt
   output logic                                    port_wake,
   output logic                                    irq
);
   import gpio_dir_input_latch_pkg::*;

   // ****************************************
   // elaboration checks
   // ****************************************
   // the logic serves exactly one full 32-bit port word
   generate
      if (PIN_COUNT != 32) begin : g_bad_count
         $error("pin count must be 32");
      end
   endgenerate

   // ****************************************
   // state
   // ****************************************
   word_t  pin_meta_r;
   word_t  pin_sync_r;
   word_t  port_input_level_r;
   word_t  pin_direction_r;
   word_t  sense_hit_latch_r;
   logic   wake_signal_source_r;
   word_t  sense_lo_r;
   word_t  sense_hi_r;
   logic [1:0] irq_status_r;
   logic [1:0] irq_mask_r;
   logic   wake_prev_r;
   logic   latch_any_prev_r;

   // ****************************************
   // bus decode
   // ****************************************
   wire    acc_wr  = psel & penable & pwrite;
   wire    full_wr = acc_wr & (pstrb == 4'hF);
   wire    sel_in  = (paddr == `OFS_PORT_INPUT_LEVEL);
   wire    sel_dir = (paddr == `OFS_PIN_DIRECTION);
   wire    sel_set = (paddr == `OFS_DIRECTION_SET_ALIAS);
   wire    sel_clr = (paddr == `OFS_DIRECTION_CLEAR_ALIAS);
   wire    sel_lat = (paddr == `OFS_SENSE_HIT_LATCH);
   wire    sel_wks = (paddr == `OFS_WAKE_SIGNAL_SOURCE);
   wire    sel_slo = (paddr == `OFS_PIN_CONFIG_SENSE_LO);
   wire    sel_shi = (paddr == `OFS_PIN_CONFIG_SENSE_HI);
   wire    sel_ist = (paddr == `OFS_IRQ_STATUS);
   wire    sel_imk = (paddr == `OFS_IRQ_MASK);
   wire    mapped  = sel_in | sel_dir | sel_set | sel_clr | sel_lat | sel_wks
                     | sel_slo | sel_shi | sel_ist | sel_imk;

   // ****************************************
   // sense detection
   // ****************************************
   function automatic logic sense_hit(input sense_t mode, input logic lvl);
      sense_hit = (mode == SENSE_HIGH) ? lvl :
                  (mode == SENSE_LOW)  ? ~lvl : 1'b0;
   endfunction

   word_t detect;
   genvar gi;
   generate
      for (gi = 0; gi < PIN_COUNT; gi++) begin : g_sense
         assign detect[gi] = sense_hit({sense_hi_r[gi], sense_lo_r[gi]},
                                       pin_sync_r[gi]);
      end
   endgenerate

   // ****************************************
   // sense latch
   // ****************************************
   // set wins over a simultaneous software clear
   wire word_t latch_clr = (full_wr & sel_lat) ? pwdata : '0;
   wire word_t latch_nxt = (sense_hit_latch_r & ~latch_clr) | detect;

   // ****************************************
   // direction
   // ****************************************
   // partial strobes leave every register untouched
   wire word_t dir_nxt =
        (full_wr & sel_dir) ? pwdata :
        (full_wr & sel_set) ? (pin_direction_r | pwdata) :
        (full_wr & sel_clr) ? (pin_direction_r & ~pwdata) :
        pin_direction_r;

   // ****************************************
   // wake and interrupts
   // ****************************************
   // latched wake is the or of all latch bits
   wire wake_nxt = wake_signal_source_r ? (|sense_hit_latch_r)
                                        : (|detect);
   wire latch_any = |sense_hit_latch_r;
   wire [1:0] irq_evt = {wake_nxt & ~wake_prev_r, latch_any & ~latch_any_prev_r};
   wire [1:0] irq_clr = (full_wr & sel_ist) ? pwdata[1:0] : 2'b00;
   wire [1:0] irq_status_nxt = (irq_status_r & ~irq_clr) | irq_evt;

   // ****************************************
   // read mux
   // ****************************************
   // both aliases read back the direction register
   wire word_t rd_mux =
        sel_in  ? port_input_level_r :
        (sel_dir | sel_set | sel_clr) ? pin_direction_r :
        sel_lat ? sense_hit_latch_r :
        sel_wks ? {31'h0000_0000, wake_signal_source_r} :
        sel_slo ? sense_lo_r :
        sel_shi ? sense_hi_r :
        sel_ist ? {30'h0000_0000, irq_status_r} :
        sel_imk ? {30'h0000_0000, irq_mask_r} : 32'h0000_0000;

   // ****************************************
   // registers
   // ****************************************
   always_ff @(posedge sys_clk) begin
      pin_meta_r <= pin_in;
      pin_sync_r <= pin_meta_r;
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         port_input_level_r   <= `RST_WORD;
         pin_direction_r      <= `RST_WORD;
         sense_hit_latch_r    <= `RST_WORD;
         wake_signal_source_r <= 1'b0;
         sense_lo_r           <= `RST_WORD;
         sense_hi_r           <= `RST_WORD;
         irq_status_r         <= 2'b00;
         irq_mask_r           <= 2'b00;
         wake_prev_r          <= 1'b0;
         latch_any_prev_r     <= 1'b0;
      end else begin
         port_input_level_r   <= pin_sync_r;
         pin_direction_r      <= dir_nxt;
         sense_hit_latch_r    <= latch_nxt;
         if (full_wr & sel_wks) begin
            wake_signal_source_r <= pwdata[`WAKE_SRC_BIT];
         end
         if (full_wr & sel_slo) begin
            sense_lo_r <= pwdata;
         end
         if (full_wr & sel_shi) begin
            sense_hi_r <= pwdata;
         end
         if (full_wr & sel_imk) begin
            irq_mask_r <= pwdata[1:0];
         end
         irq_status_r         <= irq_status_nxt;
         wake_prev_r          <= wake_nxt;
         latch_any_prev_r     <= latch_any;
      end
   end

   // ****************************************
   // bus response and outputs
   // ****************************************
   // zero wait states: the answer stands in the cycle after setup
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         prdata    <= 32'h0000_0000;
         pready    <= 1'b0;
         pslverr   <= 1'b0;
         port_wake <= 1'b0;
         irq       <= 1'b0;
      end else begin
         pready    <= psel & ~penable;
         pslverr   <= psel & ~penable & ~mapped;
         prdata    <= (psel & ~penable & ~pwrite) ? rd_mux : 32'h0000_0000;
         port_wake <= wake_nxt;
         irq       <= |(irq_status_nxt & irq_mask_r);
      end
   end

   assign pin_dir = pin_direction_r;

   // ****************************************
   // assertions
   // ****************************************
   // ****************************************
   // bus response checks
   // ****************************************
   ready_timing_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (psel & ~penable) |=> pready)
      else $error("no ready after setup");

   ready_idle_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (~(psel & ~penable)) |=> ~pready)
      else $error("ready without setup");

   slverr_map_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (psel & ~penable & ~mapped) |=> (pslverr & pready))
      else $error("unmapped access not flagged");

   slverr_ok_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (psel & ~penable & mapped) |=> ~pslverr)
      else $error("mapped access flagged");

   err_ready_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      pslverr |-> pready)
      else $error("error without ready");

   rdata_idle_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (~(psel & ~penable & ~pwrite)) |=> (prdata == 32'h0000_0000))
      else $error("read data outside read access");

   input_read_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (psel & ~penable & ~pwrite & sel_in) |=> (prdata == $past(port_input_level_r)))
      else $error("input level read wrong");

   input_level_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      ##3 (port_input_level_r == $past(pin_in, 3)))
      else $error("input level lags wrongly");

   alias_read_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (psel & ~penable & ~pwrite & (sel_set | sel_clr) & ~acc_wr)
      |=> (prdata == pin_direction_r))
      else $error("alias read differs from direction");

   // ****************************************
   // direction checks
   // ****************************************
   dir_set_apply_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (full_wr & sel_set) |=> ((pin_direction_r & $past(pwdata)) == $past(pwdata)))
      else $error("set alias did not make pins outputs");

   dir_set_keep_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (full_wr & sel_set) |=> ((pin_direction_r & ~$past(pwdata))
                               == ($past(pin_direction_r) & ~$past(pwdata))))
      else $error("set alias changed unwritten pins");

   dir_clr_apply_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (full_wr & sel_clr) |=> ((pin_direction_r & $past(pwdata)) == 32'h0000_0000))
      else $error("clear alias did not make pins inputs");

   dir_clr_keep_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (full_wr & sel_clr) |=> ((pin_direction_r & ~$past(pwdata))
                               == ($past(pin_direction_r) & ~$past(pwdata))))
      else $error("clear alias changed unwritten pins");

   dir_write_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (full_wr & sel_dir) |=> (pin_direction_r == $past(pwdata)))
      else $error("direction write lost");

   dir_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (~(full_wr & (sel_dir | sel_set | sel_clr))) |=> $stable(pin_direction_r))
      else $error("direction changed without write");

   dir_partial_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (acc_wr & (pstrb != 4'hF)) |=> $stable(pin_direction_r))
      else $error("partial write changed direction");

   // ****************************************
   // latch checks
   // ****************************************
   latch_sticky_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (~(full_wr & sel_lat)) |=> ((sense_hit_latch_r & $past(sense_hit_latch_r))
                                  == $past(sense_hit_latch_r)))
      else $error("latch bit dropped without clear");

   latch_sets_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      1'b1 |=> ((sense_hit_latch_r & $past(detect)) == $past(detect)))
      else $error("detect not latched");

   latch_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (full_wr & sel_lat) |=> ((sense_hit_latch_r & $past(pwdata) & ~$past(detect))
                               == 32'h0000_0000))
      else $error("latch bit not cleared");

   latch_only_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      1'b1 |=> ((sense_hit_latch_r & ~$past(sense_hit_latch_r) & ~$past(detect))
                == 32'h0000_0000))
      else $error("latch bit set without detect");

   sense_off_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      ((sense_hi_r | sense_lo_r) == 32'h0000_0000) |-> (detect == 32'h0000_0000))
      else $error("disabled sensing detected");

   sense_rsvd_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      1'b1 |-> ((sense_lo_r & ~sense_hi_r & detect) == 32'h0000_0000))
      else $error("unused sense code detected");

   sense_level_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      1'b1 |-> (detect == ((sense_hi_r & ~sense_lo_r & pin_sync_r)
                           | (sense_hi_r & sense_lo_r & ~pin_sync_r))))
      else $error("detect level wrong");

   // ****************************************
   // wake and interrupt checks
   // ****************************************
   wake_source_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      1'b1 |=> (port_wake == ($past(wake_signal_source_r) ? |$past(sense_hit_latch_r)
                                                          : |$past(detect))))
      else $error("wake source mismatch");

   wake_mode_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (full_wr & sel_wks) |=> (wake_signal_source_r == $past(pwdata[0])))
      else $error("wake source write lost");

   wake_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (~(full_wr & sel_wks)) |=> $stable(wake_signal_source_r))
      else $error("wake source changed without write");

   mask_write_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (full_wr & sel_imk) |=> (irq_mask_r == $past(pwdata[1:0])))
      else $error("mask write lost");

   irq_level_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      1'b1 |=> (irq == |(irq_status_r & $past(irq_mask_r))))
      else $error("interrupt level wrong");

   irq_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      1'b1 |=> ((irq_status_r & $past(irq_evt)) == $past(irq_evt)))
      else $error("event not recorded");

   irq_sticky_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (~(full_wr & sel_ist)) |=> ((irq_status_r & $past(irq_status_r))
                                  == $past(irq_status_r)))
      else $error("status bit dropped without clear");
endmodule // gpio_dir_input_latch

// ### verification/pin_model.sv
`timescale 1ns/10ps

// ****************************************
// external circuitry on the port pins
// ****************************************
module pin_model
   import gpio_dir_input_latch_pkg::*;
(
   // clock and drive level requested by the bench
   input  wire logic                            sys_clk,
   input  wire gpio_dir_input_latch_pkg::word_t drive,
   // pin levels seen by the port
   output gpio_dir_input_latch_pkg::word_t      pin_in
);
   initial pin_in = '0;
   // levels move off the clock edge, like an unrelated outside source
   always @(posedge sys_clk) pin_in <= #3 drive;
endmodule // pin_model

// ### verification/testbench.sv
`timescale 1ns/10ps
`include "gpio_dir_input_latch_regs.svh"

module testbench;
   import gpio_dir_input_latch_pkg::*;
   logic        sys_clk = 1'b0;
   logic        rst_n   = 1'b0;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [11:0] paddr   = 12'h000;
   logic [3:0]  pstrb   = 4'hF;
   word_t       pwdata  = '0;
   word_t       drive   = '0;
   word_t       pin_in, pin_dir, rd_v;
   logic [31:0] prdata;
   logic        pready, pslverr, port_wake, irq, err_v;
   int          n_mismatch = 0;
   int          num_checks = 0;

   always #5 sys_clk = ~sys_clk;

   gpio_dir_input_latch dut (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pin_in(pin_in), .pin_dir(pin_dir), .port_wake(port_wake), .irq(irq));
   pin_model pins (.sys_clk(sys_clk), .drive(drive), .pin_in(pin_in));

   // ****************************************
   // bus and compare helpers
   // ****************************************
   task automatic check(input word_t seen, input word_t exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic apb(input logic wr, input logic [11:0] a, input word_t d);
      int n;
      n = 0;
      @(posedge sys_clk);
      psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do @(posedge sys_clk); while (pready !== 1'b1 && ++n < 50);
      if (n >= 50) n_mismatch++;
      rd_v = prdata;
      err_v = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input word_t d);
      apb(1'b1, a, d);
   endtask

   task automatic rd_chk(input logic [11:0] a, input word_t exp);
      apb(1'b0, a, '0);
      check(rd_v, exp);
   endtask

   task automatic settle;
      repeat (5) @(posedge sys_clk);
   endtask

   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_reset;
      logic [11:0] ofs[6] = '{`OFS_PORT_INPUT_LEVEL, `OFS_PIN_DIRECTION,
         `OFS_DIRECTION_SET_ALIAS, `OFS_DIRECTION_CLEAR_ALIAS,
         `OFS_SENSE_HIT_LATCH, `OFS_WAKE_SIGNAL_SOURCE};
      foreach (ofs[i]) rd_chk(ofs[i], '0);
      check(pin_dir, '0);
      rd_chk(12'h7F0, '0);
      check({31'h0, err_v}, 32'h1);
   endtask

   task automatic t_dir;
      wr(`OFS_PIN_DIRECTION, 32'hA5A5_0F0F);
      rd_chk(`OFS_PIN_DIRECTION, 32'hA5A5_0F0F);
      wr(`OFS_DIRECTION_SET_ALIAS, 32'h0000_00F0);
      rd_chk(`OFS_DIRECTION_SET_ALIAS, 32'hA5A5_0FFF);
      wr(`OFS_DIRECTION_CLEAR_ALIAS, 32'hA500_000F);
      rd_chk(`OFS_DIRECTION_CLEAR_ALIAS, 32'h00A5_0FF0);
      check(pin_dir, 32'h00A5_0FF0);
   endtask

   task automatic t_in;
      drive = 32'h1234_5678;
      wr(`OFS_PORT_INPUT_LEVEL, 32'hFFFF_FFFF);
      settle;
      rd_chk(`OFS_PORT_INPUT_LEVEL, 32'h1234_5678);
      drive = 32'hEDCB_A987;
      settle;
      rd_chk(`OFS_PORT_INPUT_LEVEL, 32'hEDCB_A987);
   endtask

   task automatic t_latch;
      drive = '0;
      settle;
      // pin0 senses high, pin1 senses low, others off
      wr(`OFS_PIN_CONFIG_SENSE_LO, 32'h2);
      wr(`OFS_PIN_CONFIG_SENSE_HI, 32'h3);
      settle;
      rd_chk(`OFS_SENSE_HIT_LATCH, 32'h2);
      drive = 32'h5;
      settle;
      rd_chk(`OFS_SENSE_HIT_LATCH, 32'h3);
      drive = 32'h6;
      settle;
      wr(`OFS_SENSE_HIT_LATCH, 32'h1);
      rd_chk(`OFS_SENSE_HIT_LATCH, 32'h2);
      settle;
      check({31'h0, port_wake}, 32'h0);
      wr(`OFS_WAKE_SIGNAL_SOURCE, 32'h1);
      settle;
      check({31'h0, port_wake}, 32'h1);
      wr(`OFS_IRQ_MASK, 32'h1);
      settle;
      check({31'h0, irq}, 32'h1);
      wr(`OFS_IRQ_STATUS, 32'h3);
      settle;
      check({31'h0, irq}, 32'h0);
      wr(`OFS_SENSE_HIT_LATCH, 32'h2);
      settle;
      check({31'h0, port_wake}, 32'h0);
      wr(`OFS_WAKE_SIGNAL_SOURCE, 32'h0);
      drive = 32'h1;
      settle;
      check({31'h0, port_wake}, 32'h1);
   endtask

   // ****************************************
   // run control
   // ****************************************
   task automatic conclude;
      $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   initial begin
      repeat (6) @(posedge sys_clk);
      rst_n <= 1'b1;
      t_reset;
      t_dir;
      t_in;
      t_latch;
      conclude;
   end

   initial begin
      #100000;
      n_mismatch++;
      conclude;
   end
endmodule // testbench
